// file: rtl/sts_top.v
// Purpose: Trigger and storage sequencer of a state analyzer with APB registers
// Assumes: state_valid marks one sampled state per cycle, synchronous to pclk
// Notes: Level edits are refused while an acquisition is active
`default_nettype none
`include "sts_regs.vh"

module sts_top (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Sampled target states
  input wire state_valid,
  input wire [15:0] state_data,
  // Arm sources and peer status
  input wire arm_companion,
  input wire arm_scope,
  input wire arm_ext,
  input wire companion_on,
  input wire companion_arm_source_select_us,
  input wire scope_on,
  input wire scope_arm_source_select_us,
  input wire marker_stop,
  // Shared trace mode
  input wire peer_mode_wr,
  input wire peer_mode_rep,
  output reg mode_wr,
  output reg mode_rep,
  // Acquisition memory side
  output reg mem_wr,
  output reg [15:0] mem_data,
  output reg mem_trig,
  output reg acq_running
);

  localparam S_IDLE = 2'h0;
  localparam S_ARM = 2'h1;
  localparam S_RUN = 2'h2;

  // ==========================================================
  // Configuration storage
  reg [16:0] q_store [0:7];
  reg [16:0] q_prim [0:7];
  reg [16:0] q_sec [0:7];
  reg [15:0] occ_tgt [0:7];
  reg [2:0] dest [0:7];
  reg [15:0] pat_val [0:7];
  reg [15:0] pat_msk [0:7];
  reg [3:0] lvl_cnt;
  reg [2:0] trig_lvl;
  reg [2:0] sel;
  reg [2:0] arm_src;
  reg macro_en;
  reg [1:0] br_mode;
  reg mstop_en;
  reg [16:0] q_restart;
  reg [16:0] q_dis;
  reg refused;

  // Sequencer state
  reg [1:0] run_st;
  reg [2:0] lvl;
  reg phase;
  reg triggered;
  reg [10:0] mem_cnt;

  integer i, k;

  // Same side of the trigger boundary
  function side_ok;
    input [2:0] src;
    input [2:0] dst;
    input [2:0] trg;
    begin
      side_ok = ((src <= trg) == (dst <= trg));
    end
  endfunction

  // ==========================================================
  // APB handshake: one wait state, answer from flops
  wire acc = psel & penable;
  wire wr_en = acc & pready & pwrite;
  wire is_pat = (paddr[7:5] == `STS_PAT_PAGE) & (paddr[1:0] == 2'h0);
  wire [2:0] pidx = paddr[4:2];
  wire idle = (run_st == S_IDLE);
  wire start_cmd = wr_en & (paddr == `STS_A_CTRL) & pwdata[`STS_C_START];
  wire stop_cmd = wr_en & (paddr == `STS_A_CTRL) & pwdata[`STS_C_STOP];

  wire [3:0] cnt_m1 = lvl_cnt - 4'h1;
  wire [3:0] cnt_m2 = lvl_cnt - 4'h2;
  wire [2:0] last_lvl = cnt_m1[2:0];
  wire [2:0] mac_lvl = cnt_m2[2:0];

  // Edit command fields
  wire [1:0] ed_op = pwdata[`STS_E_OP_HI:`STS_E_OP_LO];
  wire [2:0] ed_lvl = pwdata[`STS_E_LVL_HI:`STS_E_LVL_LO];
  wire [3:0] ed_after = {1'b0, ed_lvl} + 4'h1;
  wire [2:0] ins_pos = (ed_op == `STS_ED_BEFORE) ? ed_lvl : ed_after[2:0];
  wire [2:0] new_arm = pwdata[`STS_C_ARM_HI:`STS_C_ARM_LO];
  wire [2:0] new_dest = pwdata[2:0];

  // Arm choices that would be dead or circular are refused
  wire arm_ok = ((new_arm == `STS_ARM_COMP) & companion_on & ~companion_arm_source_select_us) |
                ((new_arm == `STS_ARM_SCOPE) & scope_on & ~scope_arm_source_select_us) |
                (new_arm == `STS_ARM_RUN) | (new_arm == `STS_ARM_EXT);

  // Handshake and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (acc & ~pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (is_pat) begin
        prdata <= {pat_msk[pidx], pat_val[pidx]};
      end else begin
        case (paddr)
          `STS_A_CTRL: prdata <= {22'h00_0000, br_mode, macro_en, arm_src, mstop_en,
                                  mode_rep, 2'h0};
          `STS_A_STATUS: prdata <= {5'h00, mem_cnt, mode_rep, refused, trig_lvl,
                                    lvl_cnt, lvl, triggered, phase, run_st};
          `STS_A_EDIT: prdata <= 32'h0000_0000;
          `STS_A_LSEL: prdata <= {29'h0000_0000, sel};
          `STS_A_LSTORE: prdata <= {15'h0000, q_store[sel]};
          `STS_A_LPRIM: prdata <= {15'h0000, q_prim[sel]};
          `STS_A_LSEC: prdata <= {15'h0000, q_sec[sel]};
          `STS_A_LOCC: prdata <= {16'h0000, occ_tgt[sel]};
          `STS_A_LDEST: prdata <= {29'h0000_0000, dest[sel]};
          `STS_A_RESTART: prdata <= {15'h0000, q_restart};
          `STS_A_MDIS: prdata <= {15'h0000, q_dis};
          `STS_A_TRIG: prdata <= {29'h0000_0000, trig_lvl};
          default: pslverr <= 1'b1;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Configuration writes and level editing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        q_store[i] <= `STS_Q_ANYSTATE;
        q_prim[i] <= `STS_Q_DEF_PRIM;
        q_sec[i] <= `STS_Q_NOSTATE;
        occ_tgt[i] <= `STS_OCC_DEF;
        dest[i] <= 3'h0;
        pat_val[i] <= 16'h0000;
        pat_msk[i] <= 16'h0000;
      end
      lvl_cnt <= `STS_MIN_LVL;
      trig_lvl <= 3'h0;
      sel <= 3'h0;
      arm_src <= `STS_ARM_RUN;
      macro_en <= 1'b0;
      br_mode <= `STS_BR_OFF;
      mstop_en <= 1'b0;
      q_restart <= `STS_Q_NOSTATE;
      q_dis <= `STS_Q_NOSTATE;
      refused <= 1'b0;
      mode_rep <= 1'b0;
      mode_wr <= 1'b0;
    end else begin
      mode_wr <= 1'b0;
      // Companion changed the common trace mode
      if (peer_mode_wr) begin
        mode_rep <= peer_mode_rep;
      end
      if (wr_en & is_pat) begin
        pat_val[pidx] <= pwdata[`STS_P_VAL_HI:`STS_P_VAL_LO];
        pat_msk[pidx] <= pwdata[`STS_P_MSK_HI:`STS_P_MSK_LO];
      end else if (wr_en) begin
        case (paddr)
          `STS_A_CTRL: begin
            mode_rep <= pwdata[`STS_C_REP];
            mode_wr <= (pwdata[`STS_C_REP] != mode_rep);
            mstop_en <= pwdata[`STS_C_MSTOP];
            if (pwdata[`STS_C_BR_HI:`STS_C_BR_LO] == 2'h3) begin
              refused <= 1'b1;
            end else begin
              br_mode <= pwdata[`STS_C_BR_HI:`STS_C_BR_LO];
            end
            if (pwdata[`STS_C_MACRO] & ({1'b0, trig_lvl} >= cnt_m2)) begin
              refused <= 1'b1;
            end else begin
              macro_en <= pwdata[`STS_C_MACRO];
            end
            if (arm_ok) begin
              arm_src <= new_arm;
            end else begin
              refused <= 1'b1;
            end
          end
          `STS_A_STATUS: refused <= 1'b0;
          `STS_A_EDIT: begin
            if (!idle || {1'b0, ed_lvl} >= lvl_cnt || ed_op == 2'h0) begin
              refused <= 1'b1;
            end else if (ed_op != `STS_ED_DELETE) begin
              if (lvl_cnt == `STS_MAX_LVL) begin
                refused <= 1'b1;
              end else begin
                // Open a default level at ins_pos, shifting later ones up
                for (i = 7; i >= 0; i = i - 1) begin
                  if (i > ins_pos) begin
                    q_store[i] <= q_store[i-1];
                    q_prim[i] <= q_prim[i-1];
                    q_sec[i] <= q_sec[i-1];
                    occ_tgt[i] <= occ_tgt[i-1];
                    dest[i] <= (dest[i-1] >= ins_pos) ? dest[i-1] + 3'h1 : dest[i-1];
                  end else if (i == ins_pos) begin
                    q_store[i] <= `STS_Q_ANYSTATE;
                    q_prim[i] <= `STS_Q_DEF_PRIM;
                    q_sec[i] <= `STS_Q_NOSTATE;
                    occ_tgt[i] <= `STS_OCC_DEF;
                    dest[i] <= ins_pos;
                  end else begin
                    dest[i] <= (dest[i] >= ins_pos) ? dest[i] + 3'h1 : dest[i];
                  end
                end
                lvl_cnt <= lvl_cnt + 4'h1;
                if (trig_lvl >= ins_pos) begin
                  trig_lvl <= trig_lvl + 3'h1;
                end
              end
            end else if (lvl_cnt == `STS_MIN_LVL || ed_lvl == trig_lvl ||
                         ed_lvl == last_lvl) begin
              // Kept level: back to default terms
              q_store[ed_lvl] <= `STS_Q_ANYSTATE;
              q_prim[ed_lvl] <= `STS_Q_DEF_PRIM;
              q_sec[ed_lvl] <= `STS_Q_NOSTATE;
              occ_tgt[ed_lvl] <= `STS_OCC_DEF;
              dest[ed_lvl] <= ed_lvl;
            end else begin
              // Remove the level, shifting later ones down
              for (i = 0; i < 8; i = i + 1) begin
                if (i >= ed_lvl && i < 7) begin
                  q_store[i] <= q_store[i+1];
                  q_prim[i] <= q_prim[i+1];
                  q_sec[i] <= q_sec[i+1];
                  occ_tgt[i] <= occ_tgt[i+1];
                  dest[i] <= (dest[i+1] > ed_lvl) ? dest[i+1] - 3'h1 : dest[i+1];
                end else begin
                  dest[i] <= (dest[i] > ed_lvl) ? dest[i] - 3'h1 : dest[i];
                end
              end
              lvl_cnt <= lvl_cnt - 4'h1;
              if (trig_lvl > ed_lvl) begin
                trig_lvl <= trig_lvl - 3'h1;
              end
            end
          end
          `STS_A_LSEL: begin
            if ({1'b0, pwdata[2:0]} < lvl_cnt) begin
              sel <= pwdata[2:0];
            end else begin
              refused <= 1'b1;
            end
          end
          `STS_A_LSTORE: q_store[sel] <= pwdata[16:0];
          `STS_A_LPRIM: q_prim[sel] <= pwdata[16:0];
          `STS_A_LSEC: q_sec[sel] <= pwdata[16:0];
          `STS_A_LOCC: begin
            if (pwdata[15:0] == `STS_OCC_ZERO) begin
              refused <= 1'b1;
            end else begin
              occ_tgt[sel] <= pwdata[15:0];
            end
          end
          `STS_A_LDEST: begin
            if ({1'b0, new_dest} < lvl_cnt && side_ok(sel, new_dest, trig_lvl)) begin
              dest[sel] <= new_dest;
            end else begin
              refused <= 1'b1;
            end
          end
          `STS_A_RESTART: q_restart <= pwdata[16:0];
          `STS_A_MDIS: q_dis <= pwdata[16:0];
          `STS_A_TRIG: begin
            if (idle && {1'b0, pwdata[2:0]} < cnt_m1) begin
              trig_lvl <= pwdata[2:0];
            end else begin
              refused <= 1'b1;
            end
          end
          default: refused <= refused;
        endcase
      end
    end
  end

  // ==========================================================
  // Qualifier evaluation for the sampled state
  reg [7:0] hits;

  // Pattern recognizers: masked compare
  always @* begin
    hits = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      hits[k] = (((state_data ^ pat_val[k]) & pat_msk[k]) == 16'h0000);
    end
  end

  wire mac_here = macro_en & (lvl == mac_lvl);
  wire [16:0] cur_store = (mac_here & phase) ? q_store[last_lvl] : q_store[lvl];
  wire m_store;
  wire m_prim;
  wire m_sec;
  wire m_rst;
  wire m_dis;

  sts_qual u_q_store (.hits(hits), .qual(cur_store), .match(m_store));
  sts_qual u_q_prim (.hits(hits), .qual(q_prim[lvl]), .match(m_prim));
  sts_qual u_q_sec (.hits(hits), .qual(q_sec[lvl]), .match(m_sec));
  sts_qual u_q_rst (.hits(hits), .qual(q_restart), .match(m_rst));
  sts_qual u_q_dis (.hits(hits), .qual(q_dis), .match(m_dis));

  // Primary branch counting in ordinary levels
  wire step = (run_st == S_RUN) & state_valid;
  wire prim_hit = step & ~mac_here & (lvl != last_lvl) & m_prim;
  wire occ_done;
  reg occ_clr;

  sts_occ u_occ (
    .pclk(pclk),
    .presetn(presetn),
    .clr(occ_clr),
    .hit(prim_hit),
    .target(occ_tgt[lvl]),
    .done(occ_done)
  );

  wire [2:0] nxt_lvl = lvl + 3'h1;
  wire trig_now = occ_done & (lvl == trig_lvl);
  wire store_now = step & m_store;
  wire [10:0] next_mem_cnt = mem_cnt + {10'h000, store_now};
  wire sec_take = (br_mode == `STS_BR_PER) & m_sec & ~mac_here &
                  side_ok(lvl, dest[lvl], trig_lvl);
  wire rst_take = (br_mode == `STS_BR_RST) & m_rst;
  wire empty_after = (q_store[nxt_lvl] == `STS_Q_NOSTATE) &
                     ~(macro_en & (nxt_lvl == mac_lvl));
  wire acq_end = (next_mem_cnt == `STS_MEM_DEPTH) | (trig_now & empty_after);

  // Arm source gate
  reg arm_hit;
  always @* begin
    case (arm_src)
      `STS_ARM_RUN: arm_hit = 1'b1;
      `STS_ARM_COMP: arm_hit = arm_companion;
      `STS_ARM_SCOPE: arm_hit = arm_scope;
      `STS_ARM_EXT: arm_hit = arm_ext;
      default: arm_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Acquisition sequencer, one step per sampled state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_st <= S_IDLE;
      lvl <= 3'h0;
      phase <= 1'b0;
      triggered <= 1'b0;
      mem_cnt <= 11'h000;
      occ_clr <= 1'b0;
      mem_wr <= 1'b0;
      mem_data <= 16'h0000;
      mem_trig <= 1'b0;
      acq_running <= 1'b0;
    end else begin
      occ_clr <= 1'b0;
      mem_wr <= store_now;
      mem_data <= state_data;
      mem_trig <= store_now & trig_now;
      acq_running <= (run_st == S_RUN);
      case (run_st)
        S_IDLE: begin
          if (start_cmd) begin
            run_st <= S_ARM;
            lvl <= 3'h0;
            phase <= 1'b0;
            triggered <= 1'b0;
            mem_cnt <= 11'h000;
            occ_clr <= 1'b1;
          end
        end
        S_ARM: begin
          if (stop_cmd) begin
            run_st <= S_IDLE;
          end else if (arm_hit) begin
            run_st <= S_RUN;
          end
        end
        S_RUN: begin
          if (stop_cmd) begin
            run_st <= S_IDLE;
          end else if (state_valid) begin
            mem_cnt <= next_mem_cnt;
            if (trig_now) begin
              triggered <= 1'b1;
            end
            if (mac_here) begin
              // Enable term, then store until disable, then loop
              if (!phase && m_prim) begin
                phase <= 1'b1;
              end else if (phase && m_dis) begin
                phase <= 1'b0;
              end
            end else if (occ_done) begin
              lvl <= nxt_lvl;
              occ_clr <= 1'b1;
            end else if (sec_take && !prim_hit) begin
              lvl <= dest[lvl];
              occ_clr <= 1'b1;
            end else if (rst_take && !prim_hit) begin
              lvl <= 3'h0;
              occ_clr <= 1'b1;
            end
            if (acq_end) begin
              lvl <= 3'h0;
              phase <= 1'b0;
              occ_clr <= 1'b1;
              if (mode_rep && !(mstop_en && marker_stop)) begin
                run_st <= S_ARM;
                triggered <= 1'b0;
                mem_cnt <= 11'h000;
              end else begin
                run_st <= S_IDLE;
              end
            end
          end
        end
        default: run_st <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: shared/sts_regs.vh
// Purpose: Register map, field layout and constants of the state trigger sequencer
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:
`ifndef STS_REGS_VH
`define STS_REGS_VH

// ==========================================================
// Register byte offsets
`define STS_A_CTRL 8'h00
`define STS_A_STATUS 8'h04
`define STS_A_EDIT 8'h08
`define STS_A_LSEL 8'h0C
`define STS_A_LSTORE 8'h10
`define STS_A_LPRIM 8'h14
`define STS_A_LSEC 8'h18
`define STS_A_LOCC 8'h1C
`define STS_A_LDEST 8'h20
`define STS_A_RESTART 8'h24
`define STS_A_MDIS 8'h28
`define STS_A_TRIG 8'h2C
`define STS_PAT_PAGE 3'h2

// ==========================================================
// Control register fields
`define STS_C_START 0
`define STS_C_STOP 1
`define STS_C_REP 2
`define STS_C_MSTOP 3
`define STS_C_ARM_LO 4
`define STS_C_ARM_HI 6
`define STS_C_MACRO 7
`define STS_C_BR_LO 8
`define STS_C_BR_HI 9

// Edit register fields
`define STS_E_OP_LO 0
`define STS_E_OP_HI 1
`define STS_E_LVL_LO 4
`define STS_E_LVL_HI 6

// Pattern register fields
`define STS_P_VAL_LO 0
`define STS_P_VAL_HI 15
`define STS_P_MSK_LO 16
`define STS_P_MSK_HI 31

// Qualifier word fields
`define STS_Q_OR_LO 0
`define STS_Q_OR_HI 7
`define STS_Q_AND_LO 8
`define STS_Q_AND_HI 15
`define STS_Q_ANY 16

// ==========================================================
// Encodings
`define STS_ARM_RUN 3'h0
`define STS_ARM_COMP 3'h1
`define STS_ARM_SCOPE 3'h2
`define STS_ARM_EXT 3'h3
`define STS_BR_OFF 2'h0
`define STS_BR_PER 2'h1
`define STS_BR_RST 2'h2
`define STS_ED_BEFORE 2'h1
`define STS_ED_AFTER 2'h2
`define STS_ED_DELETE 2'h3

// ==========================================================
// Sizes and reset values
`define STS_MAX_LVL 4'h8
`define STS_MIN_LVL 4'h2
`define STS_MEM_DEPTH 11'h400
`define STS_Q_ANYSTATE 17'h1_0000
`define STS_Q_NOSTATE 17'h0_0000
`define STS_Q_DEF_PRIM 17'h0_0001
`define STS_OCC_DEF 16'h0001
`define STS_OCC_ZERO 16'h0000

`endif

// file: rtl/sts_qual.v
// Purpose: Evaluates one qualifier word against recognizer hits
// Assumes: Hits are valid for the current sampled state
// Notes: All-zero word is no state; OR group plus complemented AND group
`default_nettype none
`include "sts_regs.vh"

module sts_qual (
  // Recognizer hits and qualifier
  input wire [7:0] hits,
  input wire [16:0] qual,
  // Result
  output wire match
);

  wire [7:0] or_sel;
  wire [7:0] and_sel;

  // Plain patterns OR together, complements AND together
  assign or_sel = qual[`STS_Q_OR_HI:`STS_Q_OR_LO];
  assign and_sel = qual[`STS_Q_AND_HI:`STS_Q_AND_LO];
  assign match = qual[`STS_Q_ANY] | (|(hits & or_sel)) |
                 ((|and_sel) & ~(|(hits & and_sel)));

endmodule
`default_nettype wire

// file: rtl/sts_occ.v
// Purpose: Occurrence counter of the primary branch
// Assumes: Target is 1 to 65535
// Notes: done is combinational on the hit that completes the count
`default_nettype none
`include "sts_regs.vh"

module sts_occ (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire clr,
  input wire hit,
  input wire [15:0] target,
  // Result
  output wire done
);

  reg [15:0] cnt;
  wire [15:0] next_cnt;

  assign next_cnt = cnt + `STS_OCC_DEF;
  assign done = hit & (next_cnt >= target);

  // Count hits, restart on completion or level change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= `STS_OCC_ZERO;
    end else if (clr | done) begin
      cnt <= `STS_OCC_ZERO;
    end else if (hit) begin
      cnt <= next_cnt;
    end
  end

endmodule
`default_nettype wire

// file: verification/sts_chk.sv
// Purpose: Port-level checks of the state trigger sequencer
// Assumes: Only the ports of sts_top are visible
// Notes: Bound to the top module at the foot of this file
`default_nettype none
`include "sts_regs.vh"
module sts_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // States and memory
  input wire logic state_valid,
  input wire logic [15:0] state_data,
  input wire logic mem_wr,
  input wire logic [15:0] mem_data,
  input wire logic mem_trig,
  // Shared trace mode
  input wire logic peer_mode_wr,
  input wire logic peer_mode_rep,
  input wire logic mode_wr,
  input wire logic mode_rep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // Bus timing
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // =====
  // Storage
  a_store_echo: assert property (mem_wr |->
    $past(state_valid) && mem_data == $past(state_data))
    else $error("stored word not the sampled state");
  a_trig_stored: assert property (mem_trig |-> mem_wr)
    else $error("trigger mark without store");
  // =====
  // Trace mode
  a_mode_pulse: assert property (mode_wr |=> !mode_wr)
    else $error("mode pulse too long");
  a_peer_follow: assert property (peer_mode_wr && !(psel && penable && pwrite && pready
    && paddr == `STS_A_CTRL) |=> mode_rep == $past(peer_mode_rep))
    else $error("mode did not follow peer");
endmodule
bind sts_top sts_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .state_valid, .state_data, .mem_wr, .mem_data, .mem_trig, .peer_mode_wr,
  .peer_mode_rep, .mode_wr, .mode_rep);
`default_nettype wire

// file: verification/sts_target.sv
// Purpose: Target system presenting sampled state words
// Assumes: One word per call, valid for one clock
// Notes: Between words the data lines show the inverse of the last word
`default_nettype none
module sts_target (
  // Clock
  input wire logic pclk,
  // Sampled states
  output logic state_valid,
  output logic [15:0] state_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    state_valid = 1'b0;
    state_data = 16'h0000;
  end
  // One state per call, valid for one clock, then garbage on the idle lines
  task automatic send(input logic [15:0] w);
    @(posedge pclk);
    state_valid <= 1'b1;
    state_data <= w;
    @(posedge pclk);
    state_valid <= 1'b0;
    state_data <= ~w;
  endtask
endmodule
`default_nettype wire

// file: verification/sts_tb_top.sv
// Purpose: Self-checking bench of the state trigger sequencer
// Assumes: APB slave answers after one wait state
// Notes: Companion arm inputs and the marker stop are tied low
`default_nettype none
`include "sts_regs.vh"
`define CHK(nm, ex, got) \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
    err_count++; \
  end
module sts_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, serr, state_valid, mode_wr, mode_rep, mem_wr, mem_trig, acq_running;
  logic [15:0] state_data, mem_data, lastd;
  logic arm_ext = 1'b0, companion_on = 1'b0, scope_on = 1'b0, scope_arm_source_select_us = 1'b0;
  logic peer_mode_wr = 1'b0, peer_mode_rep = 1'b0, lastt = 1'b0;
  int err_count = 0, samples_checked = 0, nwr = 0;
  // Clock
  always #50 pclk = ~pclk;
  sts_target u_tgt (.pclk, .state_valid, .state_data);
  sts_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .state_valid, .state_data, .arm_companion(1'b0), .arm_scope(1'b0),
    .arm_ext, .companion_on, .companion_arm_source_select_us(1'b0), .scope_on,
    .scope_arm_source_select_us, .marker_stop(1'b0), .peer_mode_wr, .peer_mode_rep,
    .mode_wr, .mode_rep, .mem_wr, .mem_data, .mem_trig, .acq_running);
  // Memory side monitor
  always @(posedge pclk) begin
    if (mem_wr === 1'b1) begin
      nwr <= nwr + 1;
      lastd <= mem_data;
      lastt <= mem_trig;
    end
  end
  // =====
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sticky refusal flag is set, then cleared
  task automatic refused(input string nm);
    apb(1'b0, `STS_A_STATUS, 32'h0000_0000);
    `CHK(nm, 1'b1, q[14])
    apb(1'b1, `STS_A_STATUS, 32'h0000_0000);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
  // =====
  // Tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `STS_A_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_0100, q)
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK("unmapped", 1'b1, serr)
    apb(1'b1, `STS_A_LOCC, 32'h0000_0000);
    refused("occurrence zero");
    apb(1'b1, `STS_A_CTRL, 32'h0000_0010);
    refused("companion off");
    scope_on <= 1'b1;
    apb(1'b1, `STS_A_CTRL, 32'h0000_0020);
    apb(1'b0, `STS_A_CTRL, 32'h0000_0000);
    `CHK("scope arm", 32'h0000_0020, q)
    // Scope arm_source_select us would make a loop
    scope_arm_source_select_us <= 1'b1;
    apb(1'b1, `STS_A_CTRL, 32'h0000_0020);
    refused("circular arm");
    scope_arm_source_select_us <= 1'b0;
    // Three hits to trigger, nothing stored after it, armed externally
    apb(1'b1, 8'h40, 32'hFFFF_B03C);
    apb(1'b1, `STS_A_LPRIM, 32'h0000_0001);
    apb(1'b1, `STS_A_LOCC, 32'h0000_0003);
    apb(1'b1, `STS_A_LSEL, 32'h0000_0001);
    apb(1'b1, `STS_A_LSTORE, 32'h0000_0000);
    apb(1'b1, `STS_A_CTRL, 32'h0000_0031);
    u_tgt.send(16'h1234);
    u_tgt.send(16'hB03C);
    `CHK("stored before arm", 0, nwr)
    @(posedge pclk);
    arm_ext <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("running", 1'b1, acq_running)
    for (int i = 0; i < 5; i++) u_tgt.send(i == 1 ? 16'h1111 : 16'hB03C);
    repeat (3) @(posedge pclk);
    `CHK("stored", 4, nwr)
    `CHK("last word", 16'hB03C, lastd)
    `CHK("last trig", 1'b1, lastt)
    apb(1'b0, `STS_A_STATUS, 32'h0000_0000);
    `CHK("words", 11'h004, q[26:16])
    `CHK("idle", 2'h0, q[1:0])
    arm_ext <= 1'b0;
    // Peer sets repetitive, then our own write returns to single
    peer_mode_rep <= 1'b1;
    peer_mode_wr <= 1'b1;
    @(posedge pclk);
    peer_mode_wr <= 1'b0;
    @(posedge pclk);
    `CHK("peer mode", 1'b1, mode_rep)
    apb(1'b1, `STS_A_CTRL, 32'h0000_0000);
    @(posedge pclk);
    `CHK("own mode", 1'b0, mode_rep)
    `CHK("mode pulse", 1'b1, mode_wr)
    // Branch code 3 and a macro with no room are refused
    apb(1'b1, `STS_A_CTRL, 32'h0000_0300);
    refused("branch code");
    apb(1'b1, `STS_A_CTRL, 32'h0000_0080);
    refused("macro level");
    // Grow to eight levels, then refuse
    repeat (6) apb(1'b1, `STS_A_EDIT, 32'h0000_0002);
    apb(1'b1, `STS_A_EDIT, 32'h0000_0002);
    refused("ninth level");
    apb(1'b1, `STS_A_EDIT, 32'h0000_0073);
    apb(1'b0, `STS_A_STATUS, 32'h0000_0000);
    `CHK("levels", 4'h8, q[10:7])
    // Level 1 may not branch back across the trigger level
    apb(1'b1, `STS_A_LDEST, 32'h0000_0000);
    refused("dest crosses trigger");
    complete_run();
  end
endmodule
`default_nettype wire
